// >>> verilog/asr_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "asr_defines.vh"
module asr_ctrl #(
  parameter integer REC_CYC = `ASR_REC_CYC,
  parameter integer RD_CYC = `ASR_RD_CYC,
  parameter integer WP_CYC = `ASR_WP_CYC,
  parameter integer DIS_CYC = `ASR_DIS_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire req_valid,
  input wire req_write,
  input wire [`ASR_ADDR_W-1:0] req_addr,
  input wire [`ASR_DATA_W-1:0] req_wdata,
  input wire retention,
  output reg req_ready,
  output reg rsp_valid,
  output reg [`ASR_DATA_W-1:0] rsp_rdata,
  output reg [`ASR_ADDR_W-1:0] address_lines,
  output reg [`ASR_DATA_W-1:0] data_lines_o,
  output reg data_lines_oe,
  input wire [`ASR_DATA_W-1:0] data_lines_i,
  output reg sel_b,
  output reg wr_b,
  output reg oe_b
);
  // One-hot sequencer states.
  localparam [6:0] ST_WAIT = 7'h01;
  localparam [6:0] ST_IDLE = 7'h02;
  localparam [6:0] ST_RD = 7'h04;
  localparam [6:0] ST_ASU = 7'h08;
  localparam [6:0] ST_WR = 7'h10;
  localparam [6:0] ST_WEND = 7'h20;
  localparam [6:0] ST_GAP = 7'h40;
  // Counter width; it must hold the whole recovery wait.
  localparam integer CW = 24;
  // Terminal counts, worked out at full width and then cut to CW bits.
  localparam [31:0] REC_END_W = REC_CYC - 1;
  localparam [31:0] RD_END_W = RD_CYC + 2;
  localparam [31:0] WP_END_W = WP_CYC - 1;
  localparam [31:0] DIS_END_W = DIS_CYC - 1;
  localparam [CW-1:0] REC_END = REC_END_W[CW-1:0];
  localparam [CW-1:0] RD_END = RD_END_W[CW-1:0];
  localparam [CW-1:0] WP_END = WP_END_W[CW-1:0];
  localparam [CW-1:0] DIS_END = DIS_END_W[CW-1:0];

  reg [6:0] state_q;
  reg [CW-1:0] cnt_q;
  wire [`ASR_DATA_W-1:0] din_s2_q;
  wire ret_s2_q;

  // Read data is taken long after it settles, so per-bit flops are safe:
  // no bit can still be moving when the sequencer uses the word.
  asr_sync #(
    .WIDTH(`ASR_DATA_W),
    .RST_VAL({`ASR_DATA_W{1'b0}})
  ) asr_sync_din_i (
    .clk(clk),
    .rst_b(rst_b),
    .sync_in(data_lines_i),
    .sync_q(din_s2_q)
  );

  // Retention counts as asserted out of reset, so the recovery wait
  // only starts once the pin has been seen low through both flops.
  asr_sync #(
    .WIDTH(1),
    .RST_VAL(1'h1)
  ) asr_sync_ret_i (
    .clk(clk),
    .rst_b(rst_b),
    .sync_in(retention),
    .sync_q(ret_s2_q)
  );

  // Access sequencer; reset starts in the recovery wait.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_WAIT;
      cnt_q <= {CW{1'b0}};
      req_ready <= 1'h0;
      rsp_valid <= 1'h0;
      rsp_rdata <= 8'h00;
      address_lines <= 19'h00000;
      data_lines_o <= 8'h00;
      data_lines_oe <= 1'h0;
      sel_b <= 1'h1;
      wr_b <= 1'h1;
      oe_b <= 1'h1;
    end else begin
      rsp_valid <= 1'h0;
      if (ret_s2_q) begin
        // Retention: deselect at once and restart the wait.
        state_q <= ST_WAIT;
        cnt_q <= {CW{1'b0}};
        req_ready <= 1'h0;
        sel_b <= 1'h1;
        wr_b <= 1'h1;
        oe_b <= 1'h1;
        data_lines_oe <= 1'h0;
      end else begin
        case (state_q)
          ST_WAIT: begin
            // Hold off any access after supply returns.
            if (cnt_q >= REC_END) begin
              state_q <= ST_IDLE;
              req_ready <= 1'h1;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          ST_IDLE: begin
            if (req_valid) begin
              req_ready <= 1'h0;
              cnt_q <= {CW{1'b0}};
              address_lines <= req_addr;
              if (req_write) begin
                // Address settles a full cycle before select falls.
                oe_b <= 1'h1;
                data_lines_o <= req_wdata;
                state_q <= ST_ASU;
              end else begin
                sel_b <= 1'h0;
                oe_b <= 1'h0;
                data_lines_oe <= 1'h0;
                state_q <= ST_RD;
              end
            end
          end
          ST_ASU: begin
            // Write low with select keeps device outputs off.
            sel_b <= 1'h0;
            wr_b <= 1'h0;
            data_lines_oe <= 1'h1;
            state_q <= ST_WR;
          end
          ST_RD: begin
            // Sample after the access time plus the synchroniser.
            if (cnt_q >= RD_END) begin
              rsp_rdata <= din_s2_q;
              rsp_valid <= 1'h1;
              sel_b <= 1'h1;
              oe_b <= 1'h1;
              cnt_q <= {CW{1'b0}};
              state_q <= ST_GAP;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          ST_WR: begin
            // Pulse width covers data set-up and cycle time.
            if (cnt_q >= WP_END) begin
              wr_b <= 1'h1;
              sel_b <= 1'h1;
              state_q <= ST_WEND;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          ST_WEND: begin
            // Release data one cycle after the write ends.
            data_lines_oe <= 1'h0;
            cnt_q <= {CW{1'b0}};
            state_q <= ST_GAP;
          end
          ST_GAP: begin
            // Turnaround so device release finishes before reuse.
            if (cnt_q >= DIS_END) begin
              state_q <= ST_IDLE;
              req_ready <= 1'h1;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          default: begin
            // A state off the one-hot set falls back to a safe wait.
            state_q <= ST_WAIT;
            cnt_q <= {CW{1'b0}};
            req_ready <= 1'h0;
            sel_b <= 1'h1;
            wr_b <= 1'h1;
            oe_b <= 1'h1;
            data_lines_oe <= 1'h0;
          end
        endcase
      end
    end
  end
endmodule

// Two-flop synchroniser; only the second flop is seen outside.
module asr_sync #(
  parameter integer WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] sync_in,
  output reg [WIDTH-1:0] sync_q
);
  reg [WIDTH-1:0] meta_q;

  // The first flop may go metastable, so nothing else reads it.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= sync_in;
      sync_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/asr_defines.vh
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH
// Memory geometry.
`define ASR_ADDR_W 19
`define ASR_DATA_W 8
// Grade flag: 0 is the fast grade, 1 the slow; the cycle counts below always use the slow grade.
`define ASR_GRADE_FAST 1'h0
// Clock period in ns.
`define ASR_CLK_NS 100
// Device timing in ns, fast then slow grade.
`define ASR_TRC_FAST_NS 55
`define ASR_TRC_SLOW_NS 70
`define ASR_TWP_FAST_NS 40
`define ASR_TWP_SLOW_NS 50
`define ASR_TDS_FAST_NS 25
`define ASR_TDS_SLOW_NS 30
`define ASR_TDIS_FAST_NS 20
`define ASR_TDIS_SLOW_NS 25
// Recovery after retention in ms.
`define ASR_TREC_PD_MS 5
// Least times rounded up to cycles, never below one.
`define ASR_CYC_UP(ns) ((((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS) < 1 ? 1 : \
  (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS))
`define ASR_RD_CYC `ASR_CYC_UP(`ASR_TRC_SLOW_NS)
`define ASR_WP_CYC `ASR_CYC_UP(`ASR_TWP_SLOW_NS)
`define ASR_DIS_CYC `ASR_CYC_UP(`ASR_TDIS_SLOW_NS)
`define ASR_REC_CYC (`ASR_TREC_PD_MS * 1000000 / `ASR_CLK_NS)
`endif

// >>> bench/asr_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic retention,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [18:0] address_lines,
  input wire logic [7:0] data_lines_o,
  input wire logic data_lines_oe,
  input wire logic sel_b,
  input wire logic wr_b,
  input wire logic oe_b
);
  // All checks share the one clock and its reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_nofight; data_lines_oe |-> oe_b; endproperty
  a_nofight: assert property (p_nofight) else $error("bus fight");
  property p_drv; $rose(data_lines_oe) |-> !wr_b && !sel_b; endproperty
  a_drv: assert property (p_drv) else $error("drive off write");
  property p_adr; !sel_b |=> sel_b || $stable(address_lines); endproperty
  a_adr: assert property (p_adr) else $error("address moved");
  property p_asu; $fell(wr_b) |-> $stable(address_lines); endproperty
  a_asu: assert property (p_asu) else $error("no address set-up");
  property p_wp; $fell(wr_b) |-> !sel_b ##1 wr_b && sel_b; endproperty
  a_wp: assert property (p_wp) else $error("write pulse");
  property p_dh; $rose(wr_b) |-> data_lines_oe && $stable(data_lines_o); endproperty
  a_dh: assert property (p_dh) else $error("data hold");
  property p_rd; !oe_b |-> !sel_b && wr_b; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_rsp; $fell(oe_b) |-> ##4 rsp_valid && oe_b; endproperty
  a_rsp: assert property (p_rsp) else $error("read time");
  property p_ret; retention [*4] |-> sel_b && !req_ready; endproperty
  a_ret: assert property (p_ret) else $error("selected in hold");
  property p_rec; $fell(retention) |-> !req_ready [*8]; endproperty
  a_rec: assert property (p_rec) else $error("early access");
  c_rd: cover property (rsp_valid);
  c_wr: cover property ($rose(wr_b));
  c_ret: cover property ($fell(retention));
endmodule
bind asr_ctrl asr_ctrl_sva asr_ctrl_sva_i (.clk(clk), .rst_b(rst_b),
  .retention(retention), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .address_lines(address_lines), .data_lines_o(data_lines_o),
  .data_lines_oe(data_lines_oe), .sel_b(sel_b), .wr_b(wr_b), .oe_b(oe_b));
`default_nettype wire

// >>> bench/asr_sram_model.sv
`timescale 1ns/1ns
`default_nettype none
module asr_sram_model (
  input wire logic [18:0] address_lines,
  input wire logic [7:0] data_lines_o,
  input wire logic data_lines_oe,
  input wire logic sel_b,
  input wire logic wr_b,
  input wire logic oe_b,
  output logic [7:0] data_lines_i
);
  logic [7:0] mem [0:524287];
  logic [7:0] q;
  wire drv;
  // Outputs turn on late and off early, as a slow part would.
  assign #(35,20) drv = !sel_b && wr_b && !oe_b;
  // Stores while select and write overlap; undriven data stores unknown.
  always @* if (!sel_b && !wr_b) mem[address_lines] = data_lines_oe ? data_lines_o : 8'hXX;
  // Read data is latched while driving; released lines show its inverse.
  always @* if (drv) q = mem[address_lines];
  assign data_lines_i = data_lines_oe ? data_lines_o : (drv ? q : ~q);
endmodule
`default_nettype wire

// >>> bench/asr_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl_tb_top;
  logic clk = 0, rst_b = 0, req_valid = 0, req_write = 0, retention = 0;
  logic [18:0] req_addr = 0, address_lines;
  logic [7:0] req_wdata = 0, rsp_rdata, data_lines_o, data_lines_i;
  logic req_ready, rsp_valid, data_lines_oe, sel_b, wr_b, oe_b;
  logic [7:0] sh [logic [18:0]];
  logic [7:0] expq [$];
  int failures = 0, checks = 0, n;
  // Free-running 10 MHz clock.
  initial forever #50 clk = ~clk;
  asr_ctrl #(.REC_CYC(10)) asr_ctrl_i (.clk(clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .retention(retention), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .address_lines(address_lines),
    .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
    .data_lines_i(data_lines_i), .sel_b(sel_b), .wr_b(wr_b), .oe_b(oe_b));
  asr_sram_model asr_sram_model_i (.address_lines(address_lines),
    .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
    .sel_b(sel_b), .wr_b(wr_b), .oe_b(oe_b), .data_lines_i(data_lines_i));
  task automatic end_sim;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for the controller to be idle; n counts the cycles.
  task automatic wait_rdy;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        failures++;
        end_sim;
      end
    end
  endtask
  // One request; reads note the expected byte from the shadow copy.
  task automatic op(input logic w, input logic [18:0] ad, input logic [7:0] d);
    wait_rdy;
    req_valid = 1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    if (w) sh[ad] = d;
    else expq.push_back(sh[ad]);
    @(negedge clk);
    req_valid = 0;
  endtask
  // Each read answer is matched against the oldest note.
  always @(negedge clk) if (rsp_valid === 1'b1) chk(rsp_rdata, expq.pop_front());
  // Edge addresses, random writes, reads, a retention spell, reads again.
  initial begin
    n = $urandom(32'hf4b246bb);
    repeat (8) @(negedge clk);
    rst_b = 1;
    op(1, 19'h00000, 8'hA5);
    op(1, 19'h7FFFF, 8'h5A);
    for (int i = 0; i < 16; i++) op(1, 19'($urandom), 8'($urandom));
    foreach (sh[k]) op(0, k, 8'h00);
    wait_rdy;
    retention = 1;
    repeat (4) @(negedge clk);
    chk({7'h00, req_ready}, 8'h00);
    retention = 0;
    wait_rdy;
    chk({7'h00, n >= 10}, 8'h01);
    foreach (sh[k]) op(0, k, 8'h00);
    repeat (20) @(negedge clk);
    chk(8'(expq.size()), 8'h00);
    end_sim;
  end
endmodule
`default_nettype wire
